//--- shared/rims_consts.svh
// Operation
// - Mask bit one enables that source
// - Mask clears to zero on reset
// - Fixed event bit positions, mask equals status
// - Status read clears held bits and pin; events in the read cycle stay
// - Mode off, mask zero: nothing recorded
// - Mode off, mask set: enabled only
// - Mode on, mask zero: record all, pin idle
// - Mode on, mask set: pin enabled, record all
// - Polling mode is control bit one
// - Masked polled events give no pin timing
// - Polarity bit zero high, one low
// - Buffer empty indication always active high
// - Control bit six routes header to pin
// - Indication pin ignores receive-start mask bit
// - Indication high from header to frame end
// - Pending enabled events OR onto pin
// - Pending bits sticky; lock, unlock clear each other
`ifndef RIMS_CONSTS_SVH
`define RIMS_CONSTS_SVH

// ==========================================================
// Register offsets
`define RIMS_OFS_CTRL_ONE 8'h04
`define RIMS_OFS_IRQ_MASK 8'h0E
`define RIMS_OFS_IRQ_STATUS 8'h0F

// ==========================================================
// Reset values
`define RIMS_RST_CTRL_ONE 8'h20
`define RIMS_RST_IRQ_MASK 8'h00
`define RIMS_RST_IRQ_STATUS 8'h00

// ==========================================================
// Control register fields
`define RIMS_CTRL_POLARITY_BIT 0
`define RIMS_CTRL_POLL_MODE_BIT 1
`define RIMS_CTRL_RX_IND_EN_BIT 6

// ==========================================================
// Event bit positions, shared by mask and status
`define RIMS_EV_SYNTH_LOCK 0
`define RIMS_EV_SYNTH_UNLOCK 1
`define RIMS_EV_RX_START 2
`define RIMS_EV_FRAME_DONE 3
`define RIMS_EV_MEASUREMENT_DONE 4
`define RIMS_EV_ADDRESS_MATCH 5
`define RIMS_EV_BUFFER_ACCESS_VIOLATION 6
`define RIMS_EV_SUPPLY_LOW 7

`endif

//--- shared/rims_pkg.sv
`default_nettype none
package rims_pkg;

  // ==========================================================
  // Types
  typedef logic [7:0] rims_byte_t;

  // Whole state of the interrupt core
  typedef struct packed {
    rims_byte_t ctrlOne;
    rims_byte_t irqMask;
    rims_byte_t irqStatus;
    rims_byte_t rdData;
    logic irqPin;
    logic rxIndication;
    logic rxFrameActive;
  } rims_core_s;

  // State of the reset release chain
  typedef struct packed {
    logic [1:0] stages;
  } rims_rst_s;

endpackage

`default_nettype wire

//--- src/rims_rst_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rims_rst_sync
  import rims_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  output logic syncRst_n
);

  rims_rst_s state_reg;
  rims_rst_s state_next;

  // ==========================================================
  // Release shifts ones in; assertion is immediate
  always_comb
  begin
    state_next = state_reg;
    state_next.stages = {state_reg.stages[0], 1'b1};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Only the second stage leaves the module
  assign syncRst_n = state_reg.stages[1];

endmodule // rims_rst_sync

`default_nettype wire

//--- src/rims_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "rims_consts.svh"

module rims_core
  import rims_pkg::*;
#(
  parameter int NUM_EVENTS = 8
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [NUM_EVENTS-1:0] eventPulse,
  input wire logic phrReceived,
  input wire logic frameRxEnd,
  input wire logic fbEmptySelect,
  input wire logic fbEmptyLevel,
  output logic [7:0] ctrlOneOut,
  output logic irqPin,
  output logic rxIndicationPin
);

  // ==========================================================
  // Elaboration check
  // Bit positions are fixed, so only eight sources can be served
  if (NUM_EVENTS != 8)
  begin : gBadEvents
    $error("rims_core: NUM_EVENTS must be 8");
  end

  // ==========================================================
  // Reset release
  logic syncRst_n;

  rims_rst_sync uRstSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .syncRst_n(syncRst_n)
  );

  // ==========================================================
  // State
  rims_core_s state_reg;
  rims_core_s state_next;

  // ==========================================================
  // Decode of register port
  logic wrCtrl;
  logic wrMask;
  logic rdStatus;

  assign wrCtrl = regWrEn && (regAddr == `RIMS_OFS_CTRL_ONE);
  assign wrMask = regWrEn && (regAddr == `RIMS_OFS_IRQ_MASK);
  assign rdStatus = regRdEn && (regAddr == `RIMS_OFS_IRQ_STATUS);

  // ==========================================================
  // Control fields
  logic pollMode;
  logic activeLow;
  logic rxIndEnable;

  assign pollMode = state_reg.ctrlOne[`RIMS_CTRL_POLL_MODE_BIT];
  assign activeLow = state_reg.ctrlOne[`RIMS_CTRL_POLARITY_BIT];
  assign rxIndEnable = state_reg.ctrlOne[`RIMS_CTRL_RX_IND_EN_BIT];

  // ==========================================================
  // Which events are recorded this cycle
  // Polling records all causes; otherwise only enabled ones
  logic [7:0] recorded;
  logic [7:0] enabledEvents;

  always_comb
  begin
    enabledEvents = eventPulse & state_reg.irqMask;
    if (pollMode)
    begin
      recorded = eventPulse;
    end
    else
    begin
      recorded = enabledEvents;
    end
  end

  // ==========================================================
  // Pending status update
  logic [7:0] kept;
  logic [7:0] statusNew;

  always_comb
  begin
    // Read clears everything already held
    if (rdStatus)
    begin
      kept = 8'h00;
    end
    else
    begin
      kept = state_reg.irqStatus;
    end
    // Lock and unlock knock out each other's pending bit
    if (recorded[`RIMS_EV_SYNTH_LOCK])
    begin
      kept[`RIMS_EV_SYNTH_UNLOCK] = 1'b0;
    end
    if (recorded[`RIMS_EV_SYNTH_UNLOCK])
    begin
      kept[`RIMS_EV_SYNTH_LOCK] = 1'b0;
    end
    // New events OR in last, so they survive a clearing read
    statusNew = kept | recorded;
  end

  // ==========================================================
  // Interrupt level and pin
  logic irqActive;
  logic irqPinNew;

  always_comb
  begin
    // Only enabled pending bits reach the pin; polled ones stay silent
    irqActive = |(statusNew & state_reg.irqMask);
    if (fbEmptySelect)
    begin
      irqPinNew = fbEmptyLevel;
    end
    else
    begin
      irqPinNew = irqActive ^ activeLow;
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    state_next = state_reg;
    state_next.irqStatus = statusNew;
    state_next.irqPin = irqPinNew;
    if (wrCtrl)
    begin
      state_next.ctrlOne = regWrData;
    end
    if (wrMask)
    begin
      state_next.irqMask = regWrData;
    end
    // Read data shows the value before the clearing read
    if (regRdEn)
    begin
      case (regAddr)
        `RIMS_OFS_CTRL_ONE: state_next.rdData = state_reg.ctrlOne;
        `RIMS_OFS_IRQ_MASK: state_next.rdData = state_reg.irqMask;
        `RIMS_OFS_IRQ_STATUS: state_next.rdData = state_reg.irqStatus;
        default: state_next.rdData = 8'h00;
      endcase
    end
    // Frame window tracked regardless of the receive-start mask bit
    if (phrReceived)
    begin
      state_next.rxFrameActive = 1'b1;
    end
    else if (frameRxEnd)
    begin
      state_next.rxFrameActive = 1'b0;
    end
    state_next.rxIndication = state_next.rxFrameActive && rxIndEnable;
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge syncRst_n)
  begin
    if (!syncRst_n)
    begin
      state_reg.ctrlOne <= `RIMS_RST_CTRL_ONE;
      state_reg.irqMask <= `RIMS_RST_IRQ_MASK;
      state_reg.irqStatus <= `RIMS_RST_IRQ_STATUS;
      state_reg.rdData <= 8'h00;
      state_reg.irqPin <= 1'b0;
      state_reg.rxIndication <= 1'b0;
      state_reg.rxFrameActive <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign regRdData = state_reg.rdData;
  assign ctrlOneOut = state_reg.ctrlOne;
  assign irqPin = state_reg.irqPin;
  assign rxIndicationPin = state_reg.rxIndication;

endmodule // rims_core

`default_nettype wire

//--- sim/rims_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rims_monitor
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] eventPulse,
  input wire logic phrReceived,
  input wire logic frameRxEnd,
  input wire logic fbEmptySelect,
  input wire logic fbEmptyLevel,
  input wire logic [7:0] ctrlOneOut,
  input wire logic irqPin,
  input wire logic rxIndicationPin
);
  // ==========================================
  // Mask shadow, since the mask has no port of its own
  logic [7:0] maskReg;
  logic quiet;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      maskReg <= 8'h00;
    else if (regWrEn && regAddr == 8'h0E)
      maskReg <= regWrData;
  // Writes may move polarity or mask, so they are kept out
  assign quiet = !regWrEn && !fbEmptySelect;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_pinSet; quiet && |(eventPulse & maskReg) |=> irqPin != ctrlOneOut[0]; endproperty
  property p_maskZero; quiet && maskReg == 8'h00 |=> irqPin == ctrlOneOut[0]; endproperty
  property p_readClr;
    quiet && regRdEn && regAddr == 8'h0F && eventPulse == 8'h00 |=> irqPin == ctrlOneOut[0];
  endproperty
  property p_fbEmpty; fbEmptySelect |=> irqPin == $past(fbEmptyLevel); endproperty
  property p_ctrlWr; regWrEn && regAddr == 8'h04 |=> ctrlOneOut == $past(regWrData); endproperty
  property p_rxOn; !regWrEn && phrReceived && ctrlOneOut[6] |=> rxIndicationPin; endproperty
  property p_rxOff; frameRxEnd && !phrReceived |=> !rxIndicationPin; endproperty
  property p_rxHold; !regWrEn && rxIndicationPin && !frameRxEnd |=> rxIndicationPin; endproperty
  a_pinSet: assert property (p_pinSet) else $error("irq pin idle");
  a_maskZero: assert property (p_maskZero) else $error("irq pin active");
  a_readClr: assert property (p_readClr) else $error("pin kept");
  a_fbEmpty: assert property (p_fbEmpty) else $error("fb level");
  a_ctrlWr: assert property (p_ctrlWr) else $error("ctrl write");
  a_rxOn: assert property (p_rxOn) else $error("rx pin low");
  a_rxOff: assert property (p_rxOff) else $error("rx pin high");
  a_rxHold: assert property (p_rxHold) else $error("rx pin drop");
  c_rx: cover property (rxIndicationPin);
  c_irq: cover property (irqPin != ctrlOneOut[0]);
  c_rd: cover property (regRdEn && regAddr == 8'h0F);
endmodule // rims_monitor
bind rims_core rims_monitor mon (.core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .eventPulse(eventPulse),
  .phrReceived(phrReceived), .frameRxEnd(frameRxEnd), .fbEmptySelect(fbEmptySelect),
  .fbEmptyLevel(fbEmptyLevel), .ctrlOneOut(ctrlOneOut), .irqPin(irqPin),
  .rxIndicationPin(rxIndicationPin));
`default_nettype wire

//--- sim/rims_host.sv
`timescale 1ns/1ps
`default_nettype none
module rims_host
(
  input wire logic core_clk,
  input wire logic [7:0] regRdData,
  output var logic regWrEn,
  output var logic regRdEn,
  output var logic [7:0] regAddr,
  output var logic [7:0] regWrData
);
  // ==========================================
  // One register byte per access
  initial
  begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge core_clk);
    #1;
    regWrEn = w;
    regRdEn = !w;
    regAddr = a;
    regWrData = d;
    @(posedge core_clk);
    #1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~a; // Released bus shows no stale value
    regWrData = ~d;
    q = regRdData;
  endtask
  // Stale history is flushed right after enabling
  task automatic enableMask(input logic [7:0] m);
    logic [7:0] q;
    access(1'b1, 8'h0E, m, q);
    access(1'b0, 8'h0F, 8'h00, q);
  endtask
endmodule // rims_host
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rims_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n, regWrEn, regRdEn, phrReceived, frameRxEnd, fbEmptySelect, fbEmptyLevel;
  logic irqPin, rxIndicationPin;
  rims_byte_t regAddr, regWrData, regRdData, eventPulse, ctrlOneOut, m, e, q;
  int seed = 32'h5B2FCDAF;
  int nFail = 0;
  int nTests = 0;
  always #5 core_clk = ~core_clk;
  rims_core #(.NUM_EVENTS(8)) DUT (.core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .eventPulse(eventPulse), .phrReceived(phrReceived), .frameRxEnd(frameRxEnd),
    .fbEmptySelect(fbEmptySelect), .fbEmptyLevel(fbEmptyLevel), .ctrlOneOut(ctrlOneOut),
    .irqPin(irqPin), .rxIndicationPin(rxIndicationPin));
  rims_host host (.core_clk(core_clk), .regRdData(regRdData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
  // ==========================================
  // Checking helpers
  function automatic rims_byte_t expStat(input logic pm, input rims_byte_t mk, ev);
    return pm ? ev : ev & mk;
  endfunction
  function automatic logic expPin(input logic pol, input rims_byte_t mk, ev);
    return pol ^ (|(ev & mk));
  endfunction
  task automatic chk(input rims_byte_t got, exp);
    nTests++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      nFail++;
    end
  endtask
  task automatic pulse(input rims_byte_t ev, input logic ph, fe);
    @(posedge core_clk);
    #1;
    eventPulse = ev;
    phrReceived = ph;
    frameRxEnd = fe;
    @(posedge core_clk);
    #1;
    eventPulse = 8'h00;
    phrReceived = 1'b0;
    frameRxEnd = 1'b0;
  endtask
  task automatic conclude;
    if (nFail == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {rst_n, eventPulse, phrReceived, frameRxEnd, fbEmptySelect, fbEmptyLevel} = '0;
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    host.access(1'b0, 8'h0E, 8'h00, q); chk(q, 8'h00);
    host.access(1'b0, 8'h04, 8'h00, q); chk(q, 8'h20);
    host.access(1'b0, 8'h33, 8'h00, q); chk(q, 8'h00);
    host.access(1'b1, 8'h04, 8'h22, q);
    pulse(8'h01, 1'b0, 1'b0);
    pulse(8'h02, 1'b0, 1'b0);
    host.access(1'b0, 8'h0F, 8'h00, q); chk(q, 8'h02);
    // New event lands on the clearing read
    fork
      host.access(1'b0, 8'h0F, 8'h00, q);
      pulse(8'h80, 1'b0, 1'b0);
    join
    host.access(1'b0, 8'h0F, 8'h00, q); chk(q, 8'h80);
    for (int i = 0; i < 32; i++)
    begin
      m = i[2] ? 8'($random(seed)) : 8'h00;
      e = 8'($random(seed));
      host.access(1'b1, 8'h04, {1'b0, i[3], 4'h8, i[0], i[1]}, q);
      host.enableMask(m);
      host.access(1'b0, 8'h0E, 8'h00, q); chk(q, m);
      pulse(e, i[3] | i[4], 1'b0); // Header also arrives while the pin output is off
      chk(8'(irqPin), 8'(expPin(i[1], m, e)));
      chk(8'(rxIndicationPin), 8'(i[3]));
      host.access(1'b0, 8'h0F, 8'h00, q); chk(q, expStat(i[0], m, e));
      chk(8'(irqPin), 8'(i[1]));
      chk(8'(rxIndicationPin), 8'(i[3]));
      pulse(8'h00, 1'b0, 1'b1); chk(8'(rxIndicationPin), 8'h00);
    end
    host.access(1'b1, 8'h04, 8'h21, q);
    fbEmptySelect = 1'b1;
    fbEmptyLevel = 1'b1;
    @(posedge core_clk);
    #1 chk(8'(irqPin), 8'h01);
    fbEmptyLevel = 1'b0;
    @(posedge core_clk);
    #1 chk(8'(irqPin), 8'h00);
    conclude;
  end
endmodule // testbench
`default_nettype wire
